/* File: logic/irq_sys_pkg.sv */
// Purpose: constants for the two-level interrupt system
// Assumes: 8-bit register port, one system clock
// Notes: offsets other than the touch enable register are local choices
package irq_sys_pkg;
    localparam int NSRC = 8;
    localparam int VEC_W = 16;
    localparam logic [7:0] OFF_MAIN_EN = 8'ha8;
    localparam logic [7:0] OFF_EXT_EN1 = 8'he6;
    localparam logic [7:0] OFF_TOUCH_EN = 8'he7;
    localparam logic [7:0] OFF_PRIO = 8'hb8;
    localparam logic [7:0] OFF_PEND = 8'hc0;
    localparam logic [7:0] OFF_AUTOCLR = 8'hc1;
    localparam logic [7:0] OFF_STAT = 8'hc2;
    localparam logic [7:0] OFF_IMASK = 8'hc3;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int TOUCH_CMP_BIT = 1;
    localparam int TOUCH_DONE_BIT = 0;
    localparam int TOUCH_CMP_SRC = 6;
    localparam int TOUCH_DONE_SRC = 7;
    localparam logic [7:0] TOUCH_EN_MASK = 8'h03;
    localparam logic [7:0] MAIN_EN_RST = 8'h00;
    localparam logic [7:0] EXT_EN1_RST = 8'h00;
    localparam logic [7:0] TOUCH_EN_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [7:0] AUTOCLR_RST = 8'h00;
    localparam logic [7:0] IMASK_RST = 8'h00;
    localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
    localparam logic [7:0] SYNC_INIT = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
endpackage

/* File: logic/irq_sys.sv */
// Purpose: pending flags, enables and two-level arbitration toward the core
// Assumes: sources 0..5 are enabled by main register bits 0..5, 6..7 by the touch register
// Notes: core handshake is inst_done/take/ret; one vector per source
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

// Summary of operation
// RULE_01: several sources are arbitrated at two priority levels.
// RULE_02: a source condition sets its pending flag to one.
// RULE_03: flags set whatever the enable state of the source.
// RULE_04: an enabled source with a set flag raises a request to the core.
// RULE_05: core finishes its instruction then calls the fixed vector of the source.
// RULE_06: interrupt return resumes the interrupted program flow.
// RULE_07: a disabled source's flag never produces a request.
// RULE_08: every source has its own enable bit.
// RULE_09: source enables only count while global enable bit 7 is one.
// RULE_10: global enable zero blocks every source.
// RULE_11: chosen flags clear on vectoring; the rest wait for software.
// RULE_12: a flag still set after return requests again at once.
// RULE_13: touch enable bit 1 gates the touch compare flag.
// RULE_14: touch enable bit 0 gates the touch done flag.
// RULE_15: touch enable bits 7:2 read zero and ignore writes.
// RULE_16: high priority served first and preempts low, never the reverse.
module irq_sys (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [5:0] periph_event,
    input wire logic [1:0] ext_pin,
    input wire logic inst_done,
    input wire logic ret_done,
    output logic core_req,
    output logic core_take,
    output logic [15:0] vector_addr,
    output logic [2:0] active_src,
    output logic irq_out
);
    localparam int N = irq_sys_pkg::NSRC;

    // ******************************
    // pin synchronisers
    // ******************************
    logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r;
    // two flip-flops settle the pin, the third lets us see a change once both agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
            pin_s3_r <= 2'h0;
        end else begin
            pin_s1_r <= ext_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end
    logic [1:0] pin_prev_r;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_prev_r <= 2'h0;
        end else if (pin_s2_r == pin_s3_r) begin
            pin_prev_r <= pin_s3_r;
        end
    end
    // rising edge of a settled pin
    logic [1:0] pin_rise;
    assign pin_rise = (pin_s2_r & pin_s3_r) & ~pin_prev_r;

    // ******************************
    // registers
    // ******************************
    logic [7:0] main_en_r, ext_en1_r, touch_en_r, prio_r, autoclr_r, imask_r;
    logic [N-1:0] pend_r, stat_r;
    logic [N-1:0] cond, src_en, en_req, hw_clr, stat_set;
    logic global_en;
    assign cond = {periph_event[5:4], pin_rise, periph_event[3:0]};
    assign global_en = main_en_r[irq_sys_pkg::GLOBAL_EN_BIT];

    // plain enable, priority, auto-clear and mask registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            main_en_r <= irq_sys_pkg::MAIN_EN_RST;
            ext_en1_r <= irq_sys_pkg::EXT_EN1_RST;
            touch_en_r <= irq_sys_pkg::TOUCH_EN_RST;
            prio_r <= irq_sys_pkg::PRIO_RST;
            autoclr_r <= irq_sys_pkg::AUTOCLR_RST;
            imask_r <= irq_sys_pkg::IMASK_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                irq_sys_pkg::OFF_MAIN_EN: main_en_r <= reg_wdata;
                irq_sys_pkg::OFF_EXT_EN1: ext_en1_r <= reg_wdata;
                irq_sys_pkg::OFF_TOUCH_EN: touch_en_r <= reg_wdata & irq_sys_pkg::TOUCH_EN_MASK; // see RULE_15
                irq_sys_pkg::OFF_PRIO: prio_r <= reg_wdata;
                irq_sys_pkg::OFF_AUTOCLR: autoclr_r <= reg_wdata;
                irq_sys_pkg::OFF_IMASK: imask_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // per-source enable and flag logic
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_src
            if (g == irq_sys_pkg::TOUCH_CMP_SRC) begin : g_cmp
                assign src_en[g] = touch_en_r[irq_sys_pkg::TOUCH_CMP_BIT]; // see RULE_13
            end else if (g == irq_sys_pkg::TOUCH_DONE_SRC) begin : g_done
                assign src_en[g] = touch_en_r[irq_sys_pkg::TOUCH_DONE_BIT]; // see RULE_14
            end else begin : g_main
                assign src_en[g] = main_en_r[g]; // see RULE_08
            end
            // global gate ahead of every individual enable
            assign en_req[g] = global_en & src_en[g] & pend_r[g]; // see RULE_07, RULE_09, RULE_10
            // flag set wins over both software and hardware clear
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    pend_r[g] <= 1'b0;
                end else if (cond[g]) begin
                    pend_r[g] <= 1'b1; // see RULE_02, RULE_03
                end else if (hw_clr[g]) begin
                    pend_r[g] <= 1'b0; // see RULE_11
                end else if (reg_wr && reg_addr == irq_sys_pkg::OFF_PEND && !reg_wdata[g]) begin
                    pend_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ******************************
    // arbitration and core handshake
    // ******************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b100
    } lvl_t;
    lvl_t lvl_r, lvl_nxt;
    // set while a low routine sits preempted under a high one
    logic lvl_low_r;
    logic [2:0] low_src_r, pick_src;
    logic [N-1:0] hi_req, lo_req;
    logic pick_valid, pick_hi;
    assign hi_req = en_req & prio_r;
    assign lo_req = en_req & ~prio_r;

    // lowest numbered source wins inside a level
    always_comb begin
        pick_src = 3'h0;
        pick_hi = |hi_req;
        for (int i = N - 1; i >= 0; i--) begin
            if (pick_hi ? hi_req[i] : lo_req[i]) begin
                pick_src = 3'(i);
            end
        end
    end

    // a request may only enter a level above the one in service
    always_comb begin
        case (lvl_r)
            ST_IDLE: pick_valid = |en_req; // see RULE_01, RULE_04
            ST_LOW: pick_valid = pick_hi; // see RULE_16
            ST_HIGH: pick_valid = 1'b0;
            default: pick_valid = 1'b0;
        endcase
    end
    assign core_req = pick_valid;
    // vectoring waits for the current instruction to end
    assign core_take = pick_valid & inst_done; // see RULE_05
    assign hw_clr = core_take ? (autoclr_r & (8'h01 << pick_src)) : irq_sys_pkg::RST_ZERO;

    always_comb begin
        lvl_nxt = lvl_r;
        case (lvl_r)
            ST_IDLE: if (core_take) lvl_nxt = pick_hi ? ST_HIGH : ST_LOW;
            ST_LOW: if (core_take) lvl_nxt = ST_HIGH;
                else if (ret_done) lvl_nxt = ST_IDLE;
            ST_HIGH: if (ret_done) lvl_nxt = lvl_low_r ? ST_LOW : ST_IDLE;
            default: lvl_nxt = ST_IDLE;
        endcase
    end
    // remembers a preempted low routine so return goes back to it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lvl_low_r <= 1'b0;
            low_src_r <= 3'h0;
        end else if (lvl_r == ST_LOW && core_take) begin
            lvl_low_r <= 1'b1; // see RULE_06
            low_src_r <= active_src;
        end else if (lvl_r == ST_HIGH && ret_done) begin
            lvl_low_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lvl_r <= ST_IDLE;
        end else begin
            lvl_r <= lvl_nxt; // see RULE_12
        end
    end
    // vector and active source latched at call time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            vector_addr <= 16'h0000;
            active_src <= 3'h0;
        end else if (core_take) begin
            vector_addr <= irq_sys_pkg::VEC_BASE + 16'(irq_sys_pkg::VEC_STEP * pick_src); // see RULE_05
            active_src <= pick_src;
        end else if (lvl_r == ST_HIGH && ret_done && lvl_low_r) begin
            active_src <= low_src_r;
        end
    end

    // ******************************
    // event status and interrupt line
    // ******************************
    assign stat_set = cond;
    logic [N-1:0] stat_nxt;
    // set beats write-one-to-clear in the same cycle
    assign stat_nxt = stat_set | (stat_r & ~((reg_wr && reg_addr == irq_sys_pkg::OFF_STAT) ? reg_wdata : 8'h00));
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stat_r <= irq_sys_pkg::RST_ZERO;
        end else begin
            stat_r <= stat_nxt;
        end
    end
    // built from the next status so the line drops with the clearing write, not a cycle later
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(stat_nxt & imask_r);
        end
    end

    // ******************************
    // read port
    // ******************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                irq_sys_pkg::OFF_MAIN_EN: reg_rdata <= main_en_r;
                irq_sys_pkg::OFF_EXT_EN1: reg_rdata <= ext_en1_r;
                irq_sys_pkg::OFF_TOUCH_EN: reg_rdata <= touch_en_r; // see RULE_15
                irq_sys_pkg::OFF_PRIO: reg_rdata <= prio_r;
                irq_sys_pkg::OFF_PEND: reg_rdata <= pend_r;
                irq_sys_pkg::OFF_AUTOCLR: reg_rdata <= autoclr_r;
                irq_sys_pkg::OFF_STAT: reg_rdata <= stat_r;
                irq_sys_pkg::OFF_IMASK: reg_rdata <= imask_r;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ******************************
    // checks
    // ******************************
    property p_flag_set;
        @(posedge clk_sys) disable iff (!rst_n) cond[0] |=> pend_r[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // see RULE_02
    property p_flag_dis;
        @(posedge clk_sys) disable iff (!rst_n) (cond[1] && !src_en[1]) |=> pend_r[1];
    endproperty
    a_flag_dis: assert property (p_flag_dis) else $error("disabled flag not set"); // see RULE_03
    property p_req;
        @(posedge clk_sys) disable iff (!rst_n) (lvl_r == ST_IDLE && |en_req) |-> core_req;
    endproperty
    a_req: assert property (p_req) else $error("request missing"); // see RULE_04
    property p_take;
        @(posedge clk_sys) disable iff (!rst_n) core_take |-> inst_done && core_req;
    endproperty
    a_take: assert property (p_take) else $error("call before instruction end"); // see RULE_05
    property p_noglobal;
        @(posedge clk_sys) disable iff (!rst_n) !global_en |-> !core_req;
    endproperty
    a_noglobal: assert property (p_noglobal) else $error("request while globally off"); // see RULE_10
    property p_touch_rd;
        @(posedge clk_sys) disable iff (!rst_n) (reg_rd && reg_addr == irq_sys_pkg::OFF_TOUCH_EN) |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_touch_rd: assert property (p_touch_rd) else $error("touch bits nonzero"); // see RULE_15
    property p_no_low_preempt;
        @(posedge clk_sys) disable iff (!rst_n) lvl_r == ST_HIGH |-> !core_take;
    endproperty
    a_no_low_preempt: assert property (p_no_low_preempt) else $error("high level preempted"); // see RULE_16
    sequence s_take_hi;
        core_take && pick_hi;
    endsequence
    property p_enter_hi;
        @(posedge clk_sys) disable iff (!rst_n) s_take_hi |=> lvl_r == ST_HIGH;
    endproperty
    a_enter_hi: assert property (p_enter_hi) else $error("high level not entered"); // see RULE_01
    // hardware clear on the call for a source marked to clear itself
    property p_hw_clr;
        @(posedge clk_sys) disable iff (!rst_n) (core_take && pick_src == 3'h0 && autoclr_r[0] && !cond[0]) |=> !pend_r[0];
    endproperty
    a_hw_clr: assert property (p_hw_clr) else $error("flag not cleared on call"); // see RULE_11
    // other flags survive the call and wait for software
    property p_keep_flag;
        @(posedge clk_sys) disable iff (!rst_n)
            (core_take && pick_src == 3'h0 && !autoclr_r[0] && !(reg_wr && reg_addr == irq_sys_pkg::OFF_PEND))
            |=> pend_r[0];
    endproperty
    a_keep_flag: assert property (p_keep_flag) else $error("flag lost on call"); // see RULE_11
    // nothing enabled, nothing requested
    property p_no_en_no_req;
        @(posedge clk_sys) disable iff (!rst_n) (en_req == 8'h00) |-> !core_req;
    endproperty
    a_no_en_no_req: assert property (p_no_en_no_req) else $error("request without enabled flag"); // see RULE_07
    // source in service follows the one called
    property p_vec_src;
        @(posedge clk_sys) disable iff (!rst_n) core_take |=> active_src == $past(pick_src);
    endproperty
    a_vec_src: assert property (p_vec_src) else $error("active source wrong"); // see RULE_05
    // a flag still set after return asks again straight away
    sequence s_ret_low;
        lvl_r == ST_LOW && ret_done && !core_take;
    endsequence
    property p_rereq;
        @(posedge clk_sys) disable iff (!rst_n) s_ret_low ##1 (|en_req) |-> core_req;
    endproperty
    a_rereq: assert property (p_rereq) else $error("no request after return"); // see RULE_12
    // a high request at an instruction end breaks into a low routine
    property p_preempt;
        @(posedge clk_sys) disable iff (!rst_n) (lvl_r == ST_LOW && pick_hi && inst_done) |-> core_take;
    endproperty
    a_preempt: assert property (p_preempt) else $error("high did not preempt low"); // see RULE_16
    // with a high request waiting, the call goes to a high source
    property p_hi_first;
        @(posedge clk_sys) disable iff (!rst_n) (core_take && |hi_req) |-> prio_r[pick_src];
    endproperty
    a_hi_first: assert property (p_hi_first) else $error("low served before high"); // see RULE_16
    // unused touch enable bits never hold a one
    property p_touch_wr;
        @(posedge clk_sys) disable iff (!rst_n) (reg_wr && reg_addr == irq_sys_pkg::OFF_TOUCH_EN) |=> touch_en_r[7:2] == 6'h00;
    endproperty
    a_touch_wr: assert property (p_touch_wr) else $error("touch upper bits stored"); // see RULE_15
    property p_gate_cmp;
        @(posedge clk_sys) disable iff (!rst_n) !touch_en_r[irq_sys_pkg::TOUCH_CMP_BIT] |-> !en_req[6];
    endproperty
    a_gate_cmp: assert property (p_gate_cmp) else $error("touch compare not gated"); // see RULE_13
    property p_gate_done;
        @(posedge clk_sys) disable iff (!rst_n) !touch_en_r[irq_sys_pkg::TOUCH_DONE_BIT] |-> !en_req[7];
    endproperty
    a_gate_done: assert property (p_gate_done) else $error("touch done not gated"); // see RULE_14
    // own enable plus global enable lets a set flag through
    property p_en_bit;
        @(posedge clk_sys) disable iff (!rst_n) (main_en_r[7] && main_en_r[3] && pend_r[3]) |-> en_req[3];
    endproperty
    a_en_bit: assert property (p_en_bit) else $error("enabled flag blocked"); // see RULE_08, RULE_09
    // return from high goes back to a preempted low routine, else to idle
    sequence s_ret_back;
        lvl_r == ST_HIGH && ret_done && lvl_low_r;
    endsequence
    sequence s_ret_alone;
        lvl_r == ST_HIGH && ret_done && !lvl_low_r;
    endsequence
    property p_ret_low;
        @(posedge clk_sys) disable iff (!rst_n) s_ret_back |=> lvl_r == ST_LOW;
    endproperty
    a_ret_low: assert property (p_ret_low) else $error("preempted routine not resumed"); // see RULE_06
    property p_ret_idle;
        @(posedge clk_sys) disable iff (!rst_n) s_ret_alone |=> lvl_r == ST_IDLE;
    endproperty
    a_ret_idle: assert property (p_ret_idle) else $error("return left a stale level"); // see RULE_06
    // a settled pin edge sets its flag
    property p_pin;
        @(posedge clk_sys) disable iff (!rst_n) pin_rise[0] |=> pend_r[4];
    endproperty
    a_pin: assert property (p_pin) else $error("pin flag not set"); // see RULE_02
endmodule // irq_sys

/* File: tb/core_seq_model.sv */
// Purpose: behavioural core sequencer on the far side of the interrupt system
// Assumes: one instruction ends per cycle, or every other cycle when slow
// Notes: returns are commanded by the bench, one pulse each
`timescale 1ns/1ps
module core_seq_model #(
    parameter bit SLOW = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic go,
    input wire logic ret_req,
    input wire logic core_take,
    input wire logic [15:0] vector_addr,
    output logic inst_done,
    output logic ret_done,
    output logic [15:0] last_vec
);
    logic phase_r;
    logic took_r;
    // a slow core only reaches an instruction boundary every other cycle
    assign inst_done = go & (phase_r | ~SLOW);
    // phase, return pulse and the entry address the call jumped to
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r <= 1'b0;
            took_r <= 1'b0;
            ret_done <= 1'b0;
            last_vec <= 16'h0000;
        end else begin
            phase_r <= ~phase_r;
            took_r <= core_take;
            ret_done <= ret_req & ~ret_done;
            if (took_r) begin
                last_vec <= vector_addr;
            end
        end
    end
endmodule // core_seq_model

/* File: tb/tb_top.sv */
// Purpose: register, request, priority and status checks of the interrupt system
// Assumes: design constants from the package, core model as partner
// Notes: waits are bounded; a lost take ends the run
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, rst_n, reg_wr, reg_rd, go, ret_req, core_req, core_take, irq_out, inst_done, ret_done;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] periph_event;
    logic [1:0] ext_pin;
    logic [15:0] vector_addr, last_vec;
    logic [2:0] active_src;
    int miscompares;
    int tests_run;
    irq_sys u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_event,
        .ext_pin, .inst_done, .ret_done, .core_req, .core_take, .vector_addr, .active_src, .irq_out);
    core_seq_model #(.SLOW(1'b1)) u_core (.clk_sys, .rst_n, .go, .ret_req, .core_take, .vector_addr,
        .inst_done, .ret_done, .last_vec);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask
    task automatic ev(input logic [5:0] e);
        @(posedge clk_sys);
        periph_event <= e;
        @(posedge clk_sys);
        periph_event <= 6'h00;
    endtask
    task automatic req_is(input logic exp);
        @(posedge clk_sys);
        #1;
        chk("core_req", {15'h0000, exp}, {15'h0000, core_req});
    endtask
    // let instructions finish until the core takes; stop at once so only one call lands
    task automatic take(input logic [15:0] exp);
        int n;
        @(posedge clk_sys);
        go <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (core_take === 1'b1) break;
        end
        go <= 1'b0;
        if (n == 40) begin
            miscompares++;
            $display("ERROR core_take expected 1 seen 0");
            close_out();
        end
        @(posedge clk_sys);
        #1;
        chk("vector_addr", exp, vector_addr);
        chk("last_vec", exp, last_vec);
        chk("active_src", {13'h0000, 3'((exp - irq_sys_pkg::VEC_BASE) / irq_sys_pkg::VEC_STEP)}, {13'h0000, active_src});
    endtask
    task automatic give_ret;
        @(posedge clk_sys);
        ret_req <= 1'b1;
        @(posedge clk_sys);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_n, reg_wr, reg_rd, go, ret_req, reg_addr, reg_wdata, periph_event, ext_pin} = '0;
        miscompares = 0;
        tests_run = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(irq_sys_pkg::OFF_TOUCH_EN, 8'h00);
        wr(irq_sys_pkg::OFF_TOUCH_EN, 8'hff);
        rd(irq_sys_pkg::OFF_TOUCH_EN, 8'h03);
        wr(irq_sys_pkg::OFF_TOUCH_EN, 8'h00);
        rd(8'h10, 8'h00);
        ev(6'h01);
        req_is(1'b0);
        rd(irq_sys_pkg::OFF_PEND, 8'h01);
        wr(irq_sys_pkg::OFF_MAIN_EN, 8'h01);
        req_is(1'b0);
        wr(irq_sys_pkg::OFF_MAIN_EN, 8'h81);
        req_is(1'b1);
        take(16'h0003);
        rd(irq_sys_pkg::OFF_PEND, 8'h01);
        give_ret();
        take(16'h0003);
        wr(irq_sys_pkg::OFF_PEND, 8'h00);
        give_ret();
        req_is(1'b0);
        // touch sources clear themselves on the call
        wr(irq_sys_pkg::OFF_AUTOCLR, 8'hc0);
        wr(irq_sys_pkg::OFF_TOUCH_EN, 8'h03);
        for (int i = 0; i < 2; i++) begin
            ev(6'h10 << i);
            take(16'h0033 + 16'(8 * i));
            rd(irq_sys_pkg::OFF_PEND, 8'h00);
            give_ret();
        end
        wr(irq_sys_pkg::OFF_TOUCH_EN, 8'h01);
        ev(6'h10);
        req_is(1'b0);
        rd(irq_sys_pkg::OFF_PEND, 8'h40);
        // src2 and src3 high, src0 low
        wr(irq_sys_pkg::OFF_PEND, 8'h00);
        wr(irq_sys_pkg::OFF_MAIN_EN, 8'h8d);
        wr(irq_sys_pkg::OFF_PRIO, 8'h0c);
        ev(6'h05);
        take(16'h0013);
        req_is(1'b0);
        wr(irq_sys_pkg::OFF_PEND, 8'h01);
        give_ret();
        take(16'h0003);
        ev(6'h08);
        take(16'h001b);
        wr(irq_sys_pkg::OFF_PEND, 8'h00);
        give_ret();
        chk("active_src", 16'h0000, {13'h0000, active_src});
        give_ret();
        req_is(1'b0);
        // status, mask and the level output
        wr(irq_sys_pkg::OFF_MAIN_EN, 8'h00);
        wr(irq_sys_pkg::OFF_STAT, 8'hff);
        wr(irq_sys_pkg::OFF_IMASK, 8'h02);
        ev(6'h01);
        req_is(1'b0);
        chk("irq_out", 16'h0000, {15'h0000, irq_out});
        ev(6'h02);
        req_is(1'b0);
        chk("irq_out", 16'h0001, {15'h0000, irq_out});
        ext_pin <= 2'b01;
        repeat (6) @(posedge clk_sys);
        rd(irq_sys_pkg::OFF_PEND, 8'h13);
        rd(irq_sys_pkg::OFF_STAT, 8'h13);
        wr(irq_sys_pkg::OFF_STAT, 8'h02);
        req_is(1'b0);
        chk("irq_out", 16'h0000, {15'h0000, irq_out});
        close_out();
    end
endmodule // tb_top
